// ==== tb/test_uart_serial_control_status.sv ====
// Testbench for the serial port control block with a remote peer
`timescale 1ns/1ns
module test_uart_serial_control_status;
   localparam logic [7:0] RELOAD = 8'hfc;
   localparam int BIT_CYC = 8; // Two overflows of four ticks
   logic i_clk;
   logic i_rst_n;
   usc_pkg::usc_sfr_req_s i_sfr;
   logic [7:0] o_sfr_rdata;
   logic o_txbuf_ready;
   logic i_irq_enable;
   logic o_irq;
   logic rxd;
   logic txd;
   logic nine;
   int fails;
   int n_compared;

   usc_top usc_top_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sfr(i_sfr),
      .o_sfr_rdata(o_sfr_rdata), .o_txbuf_ready(o_txbuf_ready), .i_tmr_tick(1'b1),
      .i_tmr_reload(RELOAD), .i_irq_enable(i_irq_enable), .o_irq(o_irq),
      .i_rxd(rxd), .o_txd(txd));

   usc_peer #(.BIT_CYC(BIT_CYC)) usc_peer_i (.i_clk(i_clk), .i_txd(txd), .i_nine(nine),
      .o_rxd(rxd));

   initial
   begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("compared=%0d failed=%0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // One register access, held for exactly one sampling edge
   task automatic acc(input logic w, input logic r, input logic b, input logic [2:0] idx,
      input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      #1;
      i_sfr = {w, r, b, idx, d[0], pg, a, d};
      @(posedge i_clk);
      #1;
      i_sfr = '0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      acc(1'b1, 1'b0, 1'b0, 3'h0, usc_pkg::SFR_PAGE, a, d);
   endtask

   task automatic bwr(input logic [2:0] idx, input logic v);
      acc(1'b0, 1'b0, 1'b1, idx, usc_pkg::SFR_PAGE, usc_pkg::ADDR_CTL, {7'h00, v});
   endtask

   task automatic rdc(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] exp);
      acc(1'b0, 1'b1, 1'b0, 3'h0, pg, a, 8'h00);
      check(o_sfr_rdata, exp);
   endtask

   task automatic ctl(input logic [7:0] exp);
      rdc(usc_pkg::SFR_PAGE, usc_pkg::ADDR_CTL, exp);
   endtask

   task automatic buf_rd(input logic [7:0] exp);
      rdc(usc_pkg::SFR_PAGE, usc_pkg::ADDR_BUF, exp);
   endtask

   // Bounded wait for the peer to collect n frames
   task automatic wait_rx(input int n);
      for (int k = 0; k < 4000 && usc_peer_i.got_q.size() < n; k++)
         @(posedge i_clk);
      if (usc_peer_i.got_q.size() < n)
      begin
         fails++;
         $display("timeout waiting for frames at t=%0t", $time);
         tally_and_finish();
      end
   endtask

   // Bounded wait until the start bit shows on the transmit pin
   task automatic wait_start();
      for (int k = 0; k < 4000 && txd !== 1'b0; k++)
      begin
         @(posedge i_clk);
         #1;
      end
      if (txd !== 1'b0)
      begin
         fails++;
         $display("timeout waiting for start bit at t=%0t", $time);
         tally_and_finish();
      end
   endtask

   task automatic frame(input logic [7:0] d, input logic nb);
      check(usc_peer_i.got_q.pop_front(), d);
      check({7'h00, usc_peer_i.got9_q.pop_front()}, {7'h00, nb});
      check({7'h00, usc_peer_i.stop_q.pop_front()}, 8'h01);
   endtask

   initial
   begin
      i_rst_n = 1'b0;
      i_sfr = '0;
      i_irq_enable = 1'b0;
      nine = 1'b0;
      fails = 0;
      n_compared = 0;
      repeat (3) @(posedge i_clk);
      #1;
      i_rst_n = 1'b1;
      // Register map, unused bit and single-bit access
      ctl(usc_pkg::CTL_RESET);
      rdc(8'h00, usc_pkg::ADDR_CTL, usc_pkg::RD_UNMAPPED);
      rdc(usc_pkg::SFR_PAGE, 8'h9a, usc_pkg::RD_UNMAPPED);
      wr(usc_pkg::ADDR_CTL, 8'h00);
      ctl(8'h40);
      for (int i = 0; i < 8; i++)
      begin
         bwr(i[2:0], 1'b1);
         ctl(8'h40 | (8'h01 << i));
         bwr(i[2:0], 1'b0);
      end
      i_irq_enable = 1'b1;
      bwr(3'h1, 1'b1);
      repeat (2) @(posedge i_clk);
      #1;
      check({7'h00, o_irq}, 8'h01);
      i_irq_enable = 1'b0;
      repeat (2) @(posedge i_clk);
      #1;
      check({7'h00, o_irq}, 8'h00);
      $display("test done: registers");
      // 8-bit send with ninth bit clear: a stray ninth bit would spoil the stop
      wr(usc_pkg::ADDR_CTL, 8'h00);
      wr(usc_pkg::ADDR_BUF, 8'ha5);
      wait_start();
      // Stop bit begins nine bit times after the start edge; clear lands on it
      repeat (BIT_CYC * 9 - 2) @(posedge i_clk);
      wr(usc_pkg::ADDR_CTL, 8'h00);
      wait_rx(1);
      frame(8'ha5, 1'b1);
      ctl(8'h42);
      // 9-bit send, ninth bit follows the control field
      nine = 1'b1;
      wr(usc_pkg::ADDR_CTL, 8'h88);
      wr(usc_pkg::ADDR_BUF, 8'h3c);
      wait_rx(1);
      frame(8'h3c, 1'b1);
      wr(usc_pkg::ADDR_CTL, 8'h80);
      wr(usc_pkg::ADDR_BUF, 8'hc3);
      wait_rx(1);
      frame(8'hc3, 1'b0);
      ctl(8'hc2);
      $display("test done: transmit");
      // Fill the buffer while the shifter is busy, one write refused
      wr(usc_pkg::ADDR_BUF, 8'h01);
      wait_start();
      for (int v = 2; v < 7; v++)
         wr(usc_pkg::ADDR_BUF, v[7:0]);
      check({7'h00, o_txbuf_ready}, 8'h00);
      wait_rx(5);
      for (int v = 1; v < 6; v++)
         frame(v[7:0], 1'b0);
      repeat (200) @(posedge i_clk);
      check(usc_peer_i.got_q.size(), 8'h00);
      $display("test done: buffering");
      // Reception: enable, stop filter, overrun hold
      nine = 1'b0;
      wr(usc_pkg::ADDR_CTL, 8'h00);
      usc_peer_i.send(8'h5a, 1'b1, 1'b1);
      ctl(8'h40);
      wr(usc_pkg::ADDR_CTL, 8'h10);
      usc_peer_i.send(8'h5a, 1'b1, 1'b0);
      ctl(8'h51);
      buf_rd(8'h5a);
      repeat (40) @(posedge i_clk);
      ctl(8'h51);
      usc_peer_i.send(8'h11, 1'b1, 1'b1);
      ctl(8'h51);
      buf_rd(8'h5a);
      wr(usc_pkg::ADDR_CTL, 8'h30);
      usc_peer_i.send(8'h22, 1'b1, 1'b0);
      ctl(8'h70);
      buf_rd(8'h5a);
      usc_peer_i.send(8'h33, 1'b1, 1'b1);
      ctl(8'h75);
      buf_rd(8'h33);
      // 9-bit address filter
      nine = 1'b1;
      wr(usc_pkg::ADDR_CTL, 8'hb0);
      usc_peer_i.send(8'h44, 1'b0, 1'b1);
      ctl(8'hf0);
      usc_peer_i.send(8'h66, 1'b1, 1'b1);
      ctl(8'hf5);
      buf_rd(8'h66);
      wr(usc_pkg::ADDR_CTL, 8'h90);
      usc_peer_i.send(8'h77, 1'b0, 1'b0);
      ctl(8'hd1);
      buf_rd(8'h77);
      i_irq_enable = 1'b1;
      repeat (2) @(posedge i_clk);
      #1;
      check({7'h00, o_irq}, 8'h01);
      $display("test done: receive");
      tally_and_finish();
   end
endmodule

// ==== tb/usc_peer.sv ====
// Remote serial peer: frame receiver on the transmit pin, frame sender on the receive pin
`timescale 1ns/1ns
module usc_peer #(
   parameter int BIT_CYC = 8
) (
   input wire logic i_clk, // System clock
   input wire logic i_txd, // Block transmit pin
   input wire logic i_nine, // Nine data bits per frame
   output logic o_rxd // Block receive pin
);
   logic [7:0] got_q[$];
   logic got9_q[$];
   logic stop_q[$];
   logic [7:0] sh;
   logic b9;
   logic prev;

   // Sample just after the edge so registered pin changes have landed
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   // Send one frame, then one idle bit; line idles high
   task automatic send(input logic [7:0] d, input logic nb, input logic stop);
      wait_cyc(1);
      o_rxd = 1'b0;
      wait_cyc(BIT_CYC);
      for (int i = 0; i < 8; i++)
      begin
         o_rxd = d[i];
         wait_cyc(BIT_CYC);
      end
      if (i_nine)
      begin
         o_rxd = nb;
         wait_cyc(BIT_CYC);
      end
      o_rxd = stop;
      wait_cyc(BIT_CYC);
      o_rxd = 1'b1;
      wait_cyc(BIT_CYC);
   endtask

   initial o_rxd = 1'b1;

   // Receiver: start edge, then mid-bit samples, LSB first
   initial
   begin
      prev = 1'b1;
      forever
      begin
         wait_cyc(1);
         if (prev && !i_txd)
         begin
            wait_cyc(BIT_CYC / 2 - 1);
            for (int i = 0; i < 8; i++)
            begin
               wait_cyc(BIT_CYC);
               sh[i] = i_txd;
            end
            b9 = 1'b1;
            if (i_nine)
            begin
               wait_cyc(BIT_CYC);
               b9 = i_txd;
            end
            wait_cyc(BIT_CYC);
            got_q.push_back(sh);
            got9_q.push_back(b9);
            stop_q.push_back(i_txd);
         end
         prev = i_txd;
      end
   end
endmodule

// ==== verilog/usc_baud_timer.sv ====
// Reloading 8-bit bit timer; overflows halved into one pulse per bit
`timescale 1ns/1ns
module usc_baud_timer (
   input wire logic i_clk, // System clock
   input wire logic i_rst_n, // Async reset, active low
   input wire logic i_tick, // Timer clock enable pulse
   input wire logic [7:0] i_reload, // Reload value
   input wire logic i_restart, // Force reload and phase
   output logic o_bit_tick // One pulse per bit time
);
   logic [7:0] cnt_r, cnt_nxt;
   logic half_r, half_nxt;
   logic tick_r, tick_nxt;

   // Restart clears phase so the first overflow lands mid start bit
   always_comb
   begin
      cnt_nxt = cnt_r;
      half_nxt = half_r;
      tick_nxt = 1'b0;
      if (i_restart)
      begin
         cnt_nxt = i_reload;
         half_nxt = 1'b0;
      end
      else if (i_tick)
      begin
         if (cnt_r == usc_pkg::TMR_TOP)
         begin
            cnt_nxt = i_reload;
            half_nxt = ~half_r;
            tick_nxt = ~half_r;
         end
         else
            cnt_nxt = cnt_r + 8'h01;
      end
   end

   // Registers only
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt_r <= 8'h00;
         half_r <= 1'b0;
         tick_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         half_r <= half_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign o_bit_tick = tick_r;
endmodule

// ==== verilog/usc_fifo.sv ====
// Small synchronous FIFO with registered full and empty flags
`timescale 1ns/1ns
module usc_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 4
) (
   input wire logic i_clk, // System clock
   input wire logic i_rst_n, // Async reset, active low
   input wire logic i_in_valid, // Write request
   output logic o_in_ready, // Not full
   input wire logic [W-1:0] i_in_data, // Write data
   output logic o_out_valid, // Not empty
   input wire logic i_out_ready, // Read request
   output logic [W-1:0] o_out_data // Head word
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("usc_fifo: DEPTH must be a power of two, at least 2");

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic nf_r, nf_nxt, ne_r, ne_nxt;
   logic push, pop;

   // Pointer and flag update; flags registered to keep ports clean
   always_comb
   begin
      push = i_in_valid & nf_r;
      pop = i_out_ready & ne_r;
      wp_nxt = push ? wp_r + 1'b1 : wp_r;
      rp_nxt = pop ? rp_r + 1'b1 : rp_r;
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      nf_nxt = cnt_nxt != (AW+1)'(DEPTH);
      ne_nxt = cnt_nxt != '0;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
         nf_r <= 1'b1;
         ne_r <= 1'b0;
      end
      else
      begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
         nf_r <= nf_nxt;
         ne_r <= ne_nxt;
      end
   end

   // Storage needs no reset
   always_ff @(posedge i_clk)
   begin
      if (push)
         mem[wp_r] <= i_in_data;
   end

   assign o_in_ready = nf_r;
   assign o_out_valid = ne_r;
   assign o_out_data = mem[rp_r];
endmodule

// ==== verilog/usc_pkg.sv ====
// Shared constants and bus carrier for the serial port control block
package usc_pkg;
   localparam logic [7:0] SFR_PAGE = 8'h10;
   localparam logic [7:0] ADDR_CTL = 8'h98;
   localparam logic [7:0] ADDR_BUF = 8'h99;
   localparam logic [7:0] CTL_RESET = 8'h40;
   localparam logic [7:0] BUF_RESET = 8'h00;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;
   localparam int BIT_MODE = 7;
   localparam int BIT_ONE = 6;
   localparam int BIT_FILT = 5;
   localparam int BIT_REN = 4;
   localparam int BIT_TB8 = 3;
   localparam int BIT_RB8 = 2;
   localparam int BIT_TI = 1;
   localparam int BIT_RI = 0;
   localparam logic [2:0] IDX_ONE = 3'h6;
   localparam logic [2:0] LAST_DATA_BIT = 3'h7;
   localparam logic [7:0] TMR_TOP = 8'hff;
   localparam int TX_FIFO_DEPTH = 4;
   localparam int DATA_W = 8;

   // One special-function register access, byte or single bit
   typedef struct packed {
      logic wr;
      logic rd;
      logic bit_wr;
      logic [2:0] bit_idx;
      logic bit_val;
      logic [7:0] page;
      logic [7:0] addr;
      logic [7:0] wdata;
   } usc_sfr_req_s;
endpackage

// ==== verilog/usc_top.sv ====
// Second serial port: control register, framing, filtering and flags
// Summary of operation
// - Control bit 7 picks 8-bit (0) or 9-bit (1) framing.
// - Control bit 6 always reads one; writes to it are ignored.
// - 8-bit mode with filter set: receive-done only when stop bit is one.
// - 9-bit mode with filter set: receive-done only when ninth bit is one.
// - Receive enable zero blocks reception; one lets frames in.
// - 9-bit mode sends the live ninth-transmit bit; 8-bit mode ignores it.
// - Accepted frame stores stop bit (8-bit) or ninth bit (9-bit).
// - Transmit-done sets at the start of the stop bit.
// - Receive-done sets when the stop bit is sampled, after filtering.
// - Either done flag requests the port interrupt when enabled.
// - Control register at 0x98 page 0x10, byte and single-bit access.
// - Frame is start, eight data bits LSB first, optional ninth, stop.
// - Writing the data buffer queues that byte for sending; writes while full are dropped.
// - Frame is loaded only while receive-done is clear.
// - Bit rate is timer overflow over two; start reloads receive timer.
`timescale 1ns/1ns
module usc_top (
   input wire logic i_clk, // System clock, 250 MHz
   input wire logic i_rst_n, // Async reset, active low
   input wire usc_pkg::usc_sfr_req_s i_sfr, // Register access request
   output logic [7:0] o_sfr_rdata, // Read data, one cycle after rd
   output logic o_txbuf_ready, // Transmit buffer has room
   input wire logic i_tmr_tick, // Baud timer clock enable
   input wire logic [7:0] i_tmr_reload, // Baud timer reload value
   input wire logic i_irq_enable, // Port interrupt enable
   output logic o_irq, // Interrupt request
   input wire logic i_rxd, // Receive pin, asynchronous
   output logic o_txd // Transmit pin
);
   typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_NINTH, ST_STOP} usc_state_e;

   logic [7:0] ctl_r, ctl_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic irq_r, irq_nxt;
   logic [7:0] rxbuf_r, rxbuf_nxt;
   usc_state_e tx_st_r, tx_st_nxt, rx_st_r, rx_st_nxt;
   logic [7:0] tx_sh_r, tx_sh_nxt, rx_sh_r, rx_sh_nxt;
   logic [2:0] tx_cnt_r, tx_cnt_nxt, rx_cnt_r, rx_cnt_nxt;
   logic txd_r, txd_nxt;
   logic rx_ninth_r, rx_ninth_nxt;
   logic rxd_s1_r, rxd_s2_r, rxd_d_r;
   logic tx_tick, rx_tick, rx_go, ti_set, rx_accept, rx_stop_seen, rx_rb;
   logic fifo_push, fifo_ready, fifo_valid, fifo_pop;
   logic [7:0] fifo_data;
   logic ctl_sel, buf_sel;

   // Address decode, page must match
   function automatic logic hit(input usc_pkg::usc_sfr_req_s r, input logic [7:0] a);
      hit = (r.page == usc_pkg::SFR_PAGE) && (r.addr == a);
   endfunction

   always_comb
   begin
      ctl_sel = hit(i_sfr, usc_pkg::ADDR_CTL);
      buf_sel = hit(i_sfr, usc_pkg::ADDR_BUF);
      fifo_push = i_sfr.wr & buf_sel;
   end

   // Transmit bytes wait here; writes while full are dropped
   usc_fifo #(.W(usc_pkg::DATA_W), .DEPTH(usc_pkg::TX_FIFO_DEPTH)) u_txq (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_in_valid(fifo_push),
      .o_in_ready(fifo_ready),
      .i_in_data(i_sfr.wdata),
      .o_out_valid(fifo_valid),
      .i_out_ready(fifo_pop),
      .o_out_data(fifo_data)
   );

   // Free-running transmit bit timer
   usc_baud_timer u_tx_tmr (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_tick(i_tmr_tick),
      .i_reload(i_tmr_reload),
      .i_restart(1'b0),
      .o_bit_tick(tx_tick)
   );

   // Receive copy, realigned by each start edge seen while idle with receive enabled
   usc_baud_timer u_rx_tmr (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_tick(i_tmr_tick),
      .i_reload(i_tmr_reload),
      .i_restart(rx_go),
      .o_bit_tick(rx_tick)
   );

   // Transmitter; states advance on bit ticks, the data state holds for all eight bits
   always_comb
   begin
      tx_st_nxt = tx_st_r;
      tx_sh_nxt = tx_sh_r;
      tx_cnt_nxt = tx_cnt_r;
      txd_nxt = txd_r;
      ti_set = 1'b0;
      fifo_pop = (tx_st_r == ST_IDLE) & tx_tick & fifo_valid;
      if (tx_tick)
      begin
         case (tx_st_r)
            ST_IDLE:
               if (fifo_valid)
               begin
                  tx_sh_nxt = fifo_data;
                  txd_nxt = 1'b0;
                  tx_st_nxt = ST_START;
               end
            ST_START:
            begin
               txd_nxt = tx_sh_r[0];
               tx_sh_nxt = tx_sh_r >> 1;
               tx_cnt_nxt = 3'h0;
               tx_st_nxt = ST_DATA;
            end
            ST_DATA:
               if (tx_cnt_r != usc_pkg::LAST_DATA_BIT)
               begin
                  txd_nxt = tx_sh_r[0];
                  tx_sh_nxt = tx_sh_r >> 1;
                  tx_cnt_nxt = tx_cnt_r + 3'h1;
               end
               else if (ctl_r[usc_pkg::BIT_MODE])
               begin
                  txd_nxt = ctl_r[usc_pkg::BIT_TB8];
                  tx_st_nxt = ST_NINTH;
               end
               else
               begin
                  txd_nxt = 1'b1;
                  ti_set = 1'b1;
                  tx_st_nxt = ST_STOP;
               end
            ST_NINTH:
            begin
               txd_nxt = 1'b1;
               ti_set = 1'b1;
               tx_st_nxt = ST_STOP;
            end
            default:
               tx_st_nxt = ST_IDLE;
         endcase
      end
      else if (tx_st_r == ST_NINTH)
         txd_nxt = ctl_r[usc_pkg::BIT_TB8];
   end

   // Receiver; samples land mid-bit after the start reload
   always_comb
   begin
      rx_st_nxt = rx_st_r;
      rx_sh_nxt = rx_sh_r;
      rx_cnt_nxt = rx_cnt_r;
      rx_ninth_nxt = rx_ninth_r;
      rx_stop_seen = 1'b0;
      rx_go = (rx_st_r == ST_IDLE) & ctl_r[usc_pkg::BIT_REN] & rxd_d_r & ~rxd_s2_r;
      if (rx_go)
         rx_st_nxt = ST_START;
      else if (rx_tick)
      begin
         case (rx_st_r)
            ST_START:
            begin
               rx_cnt_nxt = 3'h0;
               rx_st_nxt = rxd_s2_r ? ST_IDLE : ST_DATA; // False start dropped
            end
            ST_DATA:
            begin
               rx_sh_nxt = {rxd_s2_r, rx_sh_r[7:1]};
               rx_cnt_nxt = rx_cnt_r + 3'h1;
               if (rx_cnt_r == usc_pkg::LAST_DATA_BIT)
                  rx_st_nxt = ctl_r[usc_pkg::BIT_MODE] ? ST_NINTH : ST_STOP;
            end
            ST_NINTH:
            begin
               rx_ninth_nxt = rxd_s2_r;
               rx_st_nxt = ST_STOP;
            end
            ST_STOP:
            begin
               rx_stop_seen = 1'b1;
               rx_st_nxt = ST_IDLE;
            end
            default:
               rx_st_nxt = ST_IDLE;
         endcase
      end
      // Captured bit: stop level in 8-bit mode, ninth bit in 9-bit mode
      rx_rb = ctl_r[usc_pkg::BIT_MODE] ? rx_ninth_r : rxd_s2_r;
      // Filter reuses the captured bit; a set receive-done flag blocks the next frame
      rx_accept = rx_stop_seen & ~ctl_r[usc_pkg::BIT_RI]
         & (~ctl_r[usc_pkg::BIT_FILT] | rx_rb);
   end

   // Control register: software first, hardware sets applied last
   always_comb
   begin
      ctl_nxt = ctl_r;
      rxbuf_nxt = rxbuf_r;
      if (i_sfr.wr & ctl_sel)
         ctl_nxt = i_sfr.wdata;
      else if (i_sfr.bit_wr & ctl_sel & (i_sfr.bit_idx != usc_pkg::IDX_ONE))
         ctl_nxt[i_sfr.bit_idx] = i_sfr.bit_val;
      ctl_nxt[usc_pkg::BIT_ONE] = 1'b1;
      if (ti_set)
         ctl_nxt[usc_pkg::BIT_TI] = 1'b1;
      if (rx_accept)
      begin
         rxbuf_nxt = rx_sh_r;
         ctl_nxt[usc_pkg::BIT_RB8] = rx_rb;
         ctl_nxt[usc_pkg::BIT_RI] = 1'b1;
      end
      // Flags are only cleared by the writes above, never on service
      irq_nxt = i_irq_enable & (ctl_r[usc_pkg::BIT_TI] | ctl_r[usc_pkg::BIT_RI]);
      rdata_nxt = rdata_r;
      if (i_sfr.rd)
      begin
         if (ctl_sel)
            rdata_nxt = ctl_r | usc_pkg::CTL_RESET;
         else if (buf_sel)
            rdata_nxt = rxbuf_r;
         else
            rdata_nxt = usc_pkg::RD_UNMAPPED;
      end
   end

   // All registers; receive pin passes two flops before use
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ctl_r <= usc_pkg::CTL_RESET;
         rxbuf_r <= usc_pkg::BUF_RESET;
         rdata_r <= 8'h00;
         irq_r <= 1'b0;
         tx_st_r <= ST_IDLE;
         tx_sh_r <= 8'h00;
         tx_cnt_r <= 3'h0;
         txd_r <= 1'b1;
         rx_st_r <= ST_IDLE;
         rx_sh_r <= 8'h00;
         rx_cnt_r <= 3'h0;
         rx_ninth_r <= 1'b0;
         rxd_s1_r <= 1'b1;
         rxd_s2_r <= 1'b1;
         rxd_d_r <= 1'b1;
      end
      else
      begin
         ctl_r <= ctl_nxt;
         rxbuf_r <= rxbuf_nxt;
         rdata_r <= rdata_nxt;
         irq_r <= irq_nxt;
         tx_st_r <= tx_st_nxt;
         tx_sh_r <= tx_sh_nxt;
         tx_cnt_r <= tx_cnt_nxt;
         txd_r <= txd_nxt;
         rx_st_r <= rx_st_nxt;
         rx_sh_r <= rx_sh_nxt;
         rx_cnt_r <= rx_cnt_nxt;
         rx_ninth_r <= rx_ninth_nxt;
         rxd_s1_r <= i_rxd;
         rxd_s2_r <= rxd_s1_r;
         rxd_d_r <= rxd_s2_r;
      end
   end

   assign o_sfr_rdata = rdata_r;
   assign o_irq = irq_r;
   assign o_txd = txd_r;
   assign o_txbuf_ready = fifo_ready;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_stop_sample;
      rx_st_r == ST_STOP && rx_tick;
   endsequence

   a_ctl_one_bit: assert property (i_sfr.rd && ctl_sel |=> o_sfr_rdata[6])
      else $error("control bit 6 read as zero");
   a_filter_eight: assert property (s_stop_sample and (ctl_r[5] && !ctl_r[7] && !rxd_s2_r
      && !ctl_r[0] && !((i_sfr.wr || i_sfr.bit_wr) && ctl_sel)) |=> !ctl_r[0])
      else $error("receive-done set despite low stop bit");
   a_filter_nine: assert property (s_stop_sample and (ctl_r[5] && ctl_r[7] && !rx_ninth_r
      && !ctl_r[0] && !((i_sfr.wr || i_sfr.bit_wr) && ctl_sel)) |=> !ctl_r[0])
      else $error("receive-done set for ninth bit zero");
   a_rx_gated: assert property (rx_st_r == ST_IDLE && !ctl_r[4] |=> rx_st_r == ST_IDLE)
      else $error("reception started while disabled");
   a_ninth_drive: assert property (tx_st_r == ST_NINTH && $past(tx_st_r == ST_NINTH)
      |-> o_txd == $past(ctl_r[3]))
      else $error("ninth transmit bit mismatch");
   a_rb_capture: assert property (rx_accept |=> ctl_r[2] == $past(rx_rb) && ctl_r[0])
      else $error("captured bit or receive-done wrong");
   a_ti_at_stop: assert property ($rose(tx_st_r == ST_STOP) |-> ctl_r[1] && o_txd)
      else $error("transmit-done missing at stop bit");
   a_irq_follow: assert property (i_irq_enable && (ctl_r[0] || ctl_r[1]) |=> o_irq)
      else $error("interrupt not requested");
   a_set_wins: assert property (ti_set |=> ctl_r[1])
      else $error("transmit-done set lost to clear");
   a_hold_full: assert property (s_stop_sample and ctl_r[0] |=> $stable(rxbuf_r))
      else $error("buffer overwritten while receive-done set");
   a_start_low: assert property (tx_st_r == ST_START ##1 tx_st_r == ST_START |-> !o_txd)
      else $error("start bit not low");
endmodule
